// >>> hw/sdrf_ctrl.sv
/*
 sdram refresh controller: precharge all, distributed or burst auto refresh,
 self refresh entry and exit with clock gating.
 every refresh sequence started from idle is preceded by a precharge all, so the memory is known to be
 idle without tracking banks here; the cost is one extra command per sequence, burst refreshes need none.
 the command pins, the clock gate, busy, the self flag and the burst count
 all come straight from flip-flops.
 assumes a neighbouring controller owns activate/read/write and reports when
 banks are open; it must hold off while o_busy is high.
 assumes the memory clock is i_clk gated by o_mem_clk_en outside this block,
 and that the memory samples the pins on the rising edge of that clock.
*/
`timescale 1ns/1ns
module sdrf_ctrl
   import sdrf_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_burst_mode,
   input wire logic i_banks_open,
   input wire logic i_self_req,
   output logic o_mem_clk_en,
   output sdrf_pins_s o_pins,
   output logic o_busy,
   output logic o_in_self,
   output logic [12:0] o_ref_count
);
   typedef enum logic [3:0] {
      ST_IDLE, ST_RAS_WAIT, ST_PRE, ST_RP_WAIT, ST_REF, ST_RFC_WAIT,
      ST_SELF_ENTER, ST_SELF, ST_CLK_START, ST_EXIT_WAIT
   } sdrf_state_e;

   sdrf_state_e state_q, state_d;
   sdrf_pins_s pins_q, pins_d;
   logic [7:0] wait_q, wait_d;
   logic [7:0] refi_q, refi_d;
   logic [12:0] burst_q, burst_d;
   logic clk_en_q, clk_en_d;
   logic in_self_q;
   logic for_self_q, for_self_d;
   // a distributed refresh that fell due and has not been issued yet
   logic owed_q, owed_d;

   // the interval counter runs freely and wraps, so waiting for the banks
   // for less than one interval never stretches the average spacing past it;
   // a tick that finds the previous refresh still pending is folded into it
   wire refi_done = (refi_q == 8'h00);
   // burst refreshes still to go after a self refresh exit
   wire burst_left = (burst_q != 13'h0000);
   // a refresh is owed when an interval has run out or a burst is pending
   wire owe_ref = owed_q || burst_left;
   // end of the current recovery or start-up wait
   wire wait_done = (wait_q == 8'h00);
   // the distributed refresh is served now, in the refresh issue state
   wire owed_take = (state_q == ST_REF) && owed_q;

   function automatic sdrf_pins_s mk(input logic cke, input logic [3:0] cmd, input logic [11:0] a);
      mk = '{cke: cke, cs_n: cmd[3], ras_n: cmd[2], cas_n: cmd[1], we_n: cmd[0], addr: a};
   endfunction

   // next-state logic; every interval is a down counter so no command
   // can slip in before its recovery time is out
   always_comb begin
      state_d = state_q;
      // recovery counter stops at zero until a state loads it again
      wait_d = wait_done ? 8'h00 : wait_q - 8'h01;
      // interval counter wraps by itself, one tick every interval
      refi_d = refi_done ? 8'(REFI_CYC - 1) : refi_q - 8'h01;
      // a new tick wins over the refresh that clears the debt in one cycle
      owed_d = refi_done || (owed_q && !owed_take);
      burst_d = burst_q;
      clk_en_d = clk_en_q;
      for_self_d = for_self_q;
      pins_d = mk(1'b1, CMD_NOP, ADDR_IDLE);
      unique case (state_q)
         ST_IDLE: begin
            if (owe_ref || i_self_req) begin
               for_self_d = !owe_ref;
               state_d = ST_RAS_WAIT;
               wait_d = 8'(RAS_CYC);
            end
         end
         // the neighbour may have activated a row just before it saw busy,
         // so a full active-to-precharge time passes before the precharge
         // tras respected
         ST_RAS_WAIT: begin
            if (wait_done) begin
               state_d = ST_PRE;
            end
         end
         ST_PRE: begin
            pins_d = mk(1'b1, CMD_PRE, ADDR_PALL);
            wait_d = 8'(RP_CYC);
            state_d = ST_RP_WAIT;
         end
         // a neighbour that still reports an open bank stalls the refresh
         // here; a stall longer than one interval loses a refresh, which
         // the neighbour must avoid
         // wait row precharge
         ST_RP_WAIT: begin
            if (wait_done && !i_banks_open) begin
               state_d = for_self_q ? ST_SELF_ENTER : ST_REF;
            end
         end
         ST_REF: begin
            pins_d = mk(1'b1, CMD_REF, ADDR_IDLE);
            wait_d = 8'(RFC_CYC);
            state_d = ST_RFC_WAIT;
            // an owed distributed refresh is served first and clears the
            // debt; only a refresh that was not owed counts off the burst
            // debt before burst
            if (!owed_q && burst_left) begin
               burst_d = burst_q - 13'h0001;
            end
         end
         ST_RFC_WAIT: begin
            // a burst goes straight on to the next refresh, the banks are
            // still idle and need no further precharge
            // nops for trfc
            if (wait_done) begin
               state_d = burst_left ? ST_REF : ST_IDLE;
            end
         end
         ST_SELF_ENTER: begin
            pins_d = mk(1'b0, CMD_REF, ADDR_IDLE);
            state_d = ST_SELF;
         end
         ST_SELF: begin
            pins_d = mk(1'b0, CMD_NOP, ADDR_IDLE);
            clk_en_d = 1'b0;
            if (!i_self_req) begin
               clk_en_d = 1'b1;
               wait_d = 8'(CKSTART_CYC);
               state_d = ST_CLK_START;
            end
         end
         ST_CLK_START: begin
            pins_d = mk(1'b0, CMD_NOP, ADDR_IDLE);
            if (wait_done) begin
               pins_d = mk(1'b1, CMD_NOP, ADDR_IDLE);
               wait_d = 8'(RFC_CYC);
               state_d = ST_EXIT_WAIT;
            end
         end
         ST_EXIT_WAIT: begin
            if (wait_done) begin
               // self refresh has just covered every row, so the interval
               // starts afresh and no earlier debt is carried out of it
               refi_d = 8'(REFI_CYC - 1);
               owed_d = 1'b0;
               if (i_burst_mode) begin
                  burst_d = 13'(REF_BURST);
                  state_d = ST_REF;
               end else begin
                  state_d = ST_IDLE;
               end
            end
         end
         // the state register has spare codes; fall back to idle, from
         // where the next refresh starts with a precharge all
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_q <= ST_IDLE;
         wait_q <= 8'h00;
         for_self_q <= 1'b0;
      end else begin
         state_q <= state_d;
         wait_q <= wait_d;
         for_self_q <= for_self_d;
      end
   end

   // command pins; reset drives a nop with clock enable high so the
   // memory never sees a stray command while the controller starts
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pins_q <= mk(1'b1, CMD_NOP, ADDR_IDLE);
      end else begin
         pins_q <= pins_d;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         refi_q <= 8'(REFI_CYC - 1);
         owed_q <= 1'b0;
         burst_q <= 13'h0000;
      end else begin
         refi_q <= refi_d;
         owed_q <= owed_d;
         burst_q <= burst_d;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         clk_en_q <= 1'b1;
         in_self_q <= 1'b0;
      end else begin
         clk_en_q <= clk_en_d;
         in_self_q <= (state_d == ST_SELF);
      end
   end

   // busy tells the neighbouring controller to keep off the pins
   logic busy_q;
   always_ff @(posedge i_clk) begin
      if (i_rst) busy_q <= 1'b0;
      else busy_q <= (state_d != ST_IDLE);
   end

   assign o_pins = pins_q;
   assign o_mem_clk_en = clk_en_q;
   assign o_in_self = in_self_q;
   assign o_busy = busy_q;
   assign o_ref_count = burst_q;
endmodule // sdrf_ctrl

// >>> hw/sdrf_pkg.sv
/*
 package for the sdram refresh controller: command encodings, pin bundle,
 timing counts derived from the 10 MHz clock.
 assumes the memory samples the command pins on the rising edge of i_clk.
*/
// Functional notes
// - precharge all only after active-to-precharge time met
// - every row refreshed within 64 ms
// - auto refresh: cs ras cas low, cke we high
// - auto refresh only idle, cke high before
// - only nops for refresh cycle time
// - one refresh per 15.6 us or 4096 burst
// - self refresh entry from idle, cke low
// - exit: restart clock, then raise cke
// - nops for refresh cycle time after exit
// - burst 4096 refreshes after exit if burst mode
// - refresh, self refresh only with banks idle
package sdrf_pkg;
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned T_RAS_NS = 42;
   localparam int unsigned T_RP_NS = 20;
   localparam int unsigned T_RFC_NS = 70;
   localparam int unsigned T_REFI_NS = 15600;
   localparam int unsigned T_CKSTART_NS = 100;
   localparam int unsigned REF_BURST = 4096;
   localparam int unsigned RAS_CYC = (T_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RFC_CYC = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned REFI_CYC = T_REFI_NS / CLK_PERIOD_NS;
   localparam int unsigned CKSTART_CYC = (T_CKSTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned A10_BIT = 10;
   localparam logic [11:0] ADDR_IDLE = 12'h000;
   localparam logic [11:0] ADDR_PALL = 12'h400;
   // command pins {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_REF = 4'h1;
   typedef struct packed {
      logic cke;
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [11:0] addr;
   } sdrf_pins_s;
endpackage

// >>> verification/sdram_refresh_precharge_all_tb_top.sv
/* bench for sdrf_ctrl with memory model
 assumes a 10 MHz clock */
`timescale 1ns/1ns
`define CHK(n,e,s) begin compares++; if ((s)!==(e)) begin err_count++; $display("Error %s %0h %0h",n,e,s); end end
module sdram_refresh_precharge_all_tb_top;
   import sdrf_pkg::*;
   logic i_clk, i_rst, i_burst_mode, i_banks_open, i_self_req, o_mem_clk_en, o_busy, o_in_self, ms, mv;
   logic [12:0] o_ref_count;
   logic [11:0] row, r0;
   sdrf_pins_s o_pins;
   int err_count = 0, compares = 0, n;
   // rows {self, burst, expected self}, cycles held
   logic [2:0] ctl [5] = '{3'h0, 3'h5, 3'h0, 3'h5, 3'h2};
   int cyc [5] = '{400, 50, 30, 50, 20};
   sdrf_ctrl dut_u (.i_clk, .i_rst, .i_burst_mode, .i_banks_open, .i_self_req,
      .o_mem_clk_en, .o_pins, .o_busy, .o_in_self, .o_ref_count);
   sdrf_mem_model mem_u (.i_clk, .i_clk_en(o_mem_clk_en), .i_pins(o_pins), .o_row(row), .o_self(ms), .o_viol(mv));
   task conclude;
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      i_clk = 0;
      forever #50 i_clk = ~i_clk;
   end
   initial begin
      {i_rst, i_burst_mode, i_banks_open, i_self_req} = 4'h8;
      repeat (20) @(negedge i_clk);
      i_rst = 0;
      @(negedge i_clk);
      `CHK("busy", 1'b0, o_busy)
      for (int i = 0; i < 5; i++) begin
         {i_self_req, i_burst_mode} = ctl[i][2:1];
         repeat (cyc[i]) @(negedge i_clk);
         `CHK("self", ctl[i][0], o_in_self)
         `CHK("mself", ctl[i][0], ms)
         `CHK("clken", !ctl[i][0], o_mem_clk_en)
      end
      `CHK("count", 1'b1, o_ref_count != 0)
      // burst takes three cycles a refresh
      for (n = 0; n < 20000 && o_busy !== 1'b0; n++) @(negedge i_clk);
      // a burst that never ends counts as a mismatch and skips to the violation check and the report
      if (n == 20000) err_count++;
      else begin
         `CHK("drain", 13'h0000, o_ref_count)
         {i_burst_mode, i_banks_open} = 2'h1;
         repeat (10) @(negedge i_clk);
         r0 = row;
         repeat (400) @(negedge i_clk);
         `CHK("held", r0, row)
         i_banks_open = 0;
         repeat (200) @(negedge i_clk);
         `CHK("moved", 1'b1, row != r0)
      end
      `CHK("viol", 1'b0, mv)
      conclude();
   end
endmodule // sdram_refresh_precharge_all_tb_top

// >>> verification/sdrf_ctrl_monitor.sv
/* pin-order checks on sdrf_ctrl
 assumes bound to sdrf_ctrl */
`timescale 1ns/1ns
module sdrf_ctrl_monitor
   import sdrf_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic o_mem_clk_en,
   input wire sdrf_pins_s o_pins,
   input wire logic o_busy
);
   logic [3:0] c;
   // command seen by the memory
   assign c = {o_pins.cs_n, o_pins.ras_n, o_pins.cas_n, o_pins.we_n};
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   property p_a10; c == CMD_PRE |-> o_pins.addr[A10_BIT]; endproperty
   a_a10: assert property (p_a10) else $error("a10");
   property p_rp; c == CMD_PRE |=> c == CMD_NOP; endproperty
   a_rp: assert property (p_rp) else $error("rp");
   property p_rfc; c == CMD_REF && o_pins.cke |=> c == CMD_NOP; endproperty
   a_rfc: assert property (p_rfc) else $error("rfc");
   property p_cke; c == CMD_REF |-> $past(o_pins.cke); endproperty
   a_cke: assert property (p_cke) else $error("cke");
   property p_in; $fell(o_pins.cke) |-> c == CMD_REF; endproperty
   a_in: assert property (p_in) else $error("in");
   property p_stop; !o_mem_clk_en |-> !o_pins.cke; endproperty
   a_stop: assert property (p_stop) else $error("stop");
   property p_out; $rose(o_mem_clk_en) |-> !o_pins.cke ##1 !o_pins.cke; endproperty
   a_out: assert property (p_out) else $error("out");
   property p_nop; $rose(o_pins.cke) |-> c == CMD_NOP; endproperty
   a_nop: assert property (p_nop) else $error("nop");
   property p_pre; $rose(o_busy) |-> ##3 c == CMD_PRE; endproperty
   a_pre: assert property (p_pre) else $error("pre");
endmodule // sdrf_ctrl_monitor
bind sdrf_ctrl sdrf_ctrl_monitor mon_u (.i_clk, .i_rst, .o_mem_clk_en, .o_pins, .o_busy);

// >>> verification/sdrf_mem_model.sv
/* memory model: rows, self state, spacing faults
 assumes pins move after the rising edge */
`timescale 1ns/1ns
module sdrf_mem_model
   import sdrf_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_clk_en,
   input wire sdrf_pins_s i_pins,
   output logic [11:0] o_row,
   output logic o_self,
   output logic o_viol
);
   logic [3:0] c;
   logic ck, idl, rec;
   assign c = {i_pins.cs_n, i_pins.ras_n, i_pins.cas_n, i_pins.we_n};
   initial {o_row, o_self, o_viol, ck, idl, rec} = 17'h00004;
   // only cke counts in self refresh, clock first
   always @(posedge i_clk) begin
      if (o_self) begin
         if (i_pins.cke) begin
            o_viol <= o_viol | !i_clk_en;
            o_self <= 1'b0;
            rec <= 1'b1;
         end
      end else if (i_clk_en) begin
         rec <= c != CMD_NOP;
         if (rec && c != CMD_NOP) o_viol <= 1'b1;
         if (c == CMD_PRE && i_pins.addr[A10_BIT]) idl <= 1'b1;
         if (c == CMD_REF) begin
            if (!idl || !ck) o_viol <= 1'b1;
            if (i_pins.cke) o_row <= o_row + 12'h001;
            else o_self <= 1'b1;
         end
         ck <= i_pins.cke;
      end
   end
endmodule // sdrf_mem_model
